// ---- rtl/sfrc_top.v ----
// Command logic of a serial NOR flash: configuration write and array reads.
// Assumes link pins from outside the clock domain and a same-clock array port.
//
// Functional notes
// - Configuration write accepted only while the write unlock latch is set.
// - Write unlock command sets the write unlock latch.
// - Configuration write runs only if chip select rises after exactly eight data bits.
// - Self-timed write cycle starts when chip select rises.
// - Busy flag high during the cycle; completion clears busy and unlock latch.
// - Address sampled on rising edges, data driven on falling edges.
// - Read address increments per byte and wraps to zero.
// - Reads rejected while a write cycle runs, leaving the cycle intact.
// - Four-wire fast read uses 4, 6, 8 or 10 dummy clocks from parameter.
// - Double-rate fast read: address and data on both edges, six dummy clocks.
// - Dual output read: address on one line, data two bits per clock.
// - Dual I/O read moves address, mode and data two bits per clock.
// - Mode bits 5:4 equal 1,0 let the next read skip the opcode.
// - Other mode values or the mode reset command restore normal opcodes.
// - Double-rate dual I/O read supports the same continuous mode.
// - Quad output read returns four bits per clock on falling edges.
// - Dummy select bit gives dual I/O read 0 or 4 dummy clocks.
// - Learning pattern driven on active lines during the last eight dummy clocks of fast and double-rate reads when enabled.
`timescale 1ns/1ps
`default_nettype none
`include "sfrc_defines.vh"
module sfrc_top #(
  parameter TW_CYCLES = `SFRC_TW_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Serial link
  input wire SCLK,
  input wire CS_N,
  input wire [3:0] IO_I,
  output wire [3:0] IO_O,
  output wire [3:0] IO_OE,
  // Array read port
  output wire MEM_RD,
  output wire [23:0] MEM_ADDR,
  input wire [7:0] MEM_RDATA,
  input wire MEM_VALID,
  // Status and configuration
  input wire EXT_BUSY,
  input wire FOUR_WIRE_COMMAND_MODE,
  output wire BUSY_FLAG,
  output wire WRITE_UNLOCK_LATCH,
  output wire [7:0] CONFIG_REG,
  output wire [7:0] READ_PARAM,
  output wire CONTINUOUS_MODE
);
  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_CMD = 3'h1;
  localparam [2:0] PH_ADDR = 3'h2;
  localparam [2:0] PH_MODE = 3'h3;
  localparam [2:0] PH_DUMMY = 3'h4;
  localparam [2:0] PH_DATA = 3'h5;
  localparam [2:0] PH_STAT = 3'h6;
  localparam [2:0] PH_IGN = 3'h7;
  localparam [19:0] TW_LAST = TW_CYCLES[19:0] - 20'h00001;

  reg [2:0] phase_q;
  reg [7:0] cmd_q, cont_cmd_q;
  reg [5:0] bit_cnt_q;
  reg [23:0] in_sr_q;
  reg [3:0] dum_q;
  reg [7:0] osr_q;
  reg [3:0] ocnt_q;
  reg [3:0] io_o_q, io_oe_q;
  reg wel_q, wip_q, busy_q, cont_q;
  reg [19:0] tw_cnt_q;
  reg [7:0] cfg_q, param_q;
  reg [23:0] fetch_addr_q, mem_addr_q;
  reg mem_rd_q, pend_q, drop_q, fetch_on_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  reg [5:0] sy1_q, sy2_q;
  reg sclk_d_q, cs_d_q;
  wire cs_n = sy2_q[5];
  wire sclk = sy2_q[4];
  wire [3:0] io = sy2_q[3:0];
  always @(posedge CLK) begin
    if (RST) begin
      sy1_q <= 6'h20;
      sy2_q <= 6'h20;
      sclk_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      sy1_q <= {CS_N, SCLK, IO_I};
      sy2_q <= sy1_q;
      sclk_d_q <= sclk;
      cs_d_q <= cs_n;
    end
  end
  wire rise = sclk & ~sclk_d_q & ~cs_n;
  wire fall = ~sclk & sclk_d_q & ~cs_n;
  wire cs_fall = ~cs_n & cs_d_q;
  wire cs_rise = cs_n & ~cs_d_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command properties
  function is_read;
    input [7:0] op;
    begin
      is_read = (op == `SFRC_OP_RD) || (op == `SFRC_OP_FAST) ||
                (op == `SFRC_OP_DTR_FAST) || (op == `SFRC_OP_DUAL_OUT) ||
                (op == `SFRC_OP_DUAL_IO) || (op == `SFRC_OP_DTR_DUAL_IO) ||
                (op == `SFRC_OP_QUAD_OUT);
    end
  endfunction

  function [3:0] lane_mask;
    input [2:0] w;
    begin
      case (w)
        3'h2: lane_mask = 4'h3;
        3'h4: lane_mask = 4'hf;
        default: lane_mask = 4'h2;
      endcase
    end
  endfunction

  wire four = FOUR_WIRE_COMMAND_MODE;
  wire busy_any = wip_q | EXT_BUSY;
  wire is_dtr = (cmd_q == `SFRC_OP_DTR_FAST) || (cmd_q == `SFRC_OP_DTR_DUAL_IO);
  wire dual_io = (cmd_q == `SFRC_OP_DUAL_IO) || (cmd_q == `SFRC_OP_DTR_DUAL_IO);
  wire has_mode = dual_io;
  wire [2:0] aw = four ? 3'h4 : (dual_io ? 3'h2 : 3'h1);
  reg [2:0] dw;
  always @* begin
    dw = 3'h1;
    if (four)
      dw = 3'h4;
    else if (cmd_q == `SFRC_OP_QUAD_OUT)
      dw = 3'h4;
    else if (dual_io || cmd_q == `SFRC_OP_DUAL_OUT)
      dw = 3'h2;
  end
  wire [2:0] ow = (phase_q == PH_STAT) ? (four ? 3'h4 : 3'h1) : dw;
  wire [3:0] param_dum = `SFRC_FOUR_WIRE_DUMMY_BASE +
                         {1'b0, param_q[`SFRC_PARAM_DUM_HI:`SFRC_PARAM_DUM_LO], 1'b0};
  reg [3:0] dummy_n;
  always @* begin
    case (cmd_q)
      `SFRC_OP_FAST: dummy_n = four ? param_dum : `SFRC_FAST_DUMMY;
      `SFRC_OP_DTR_FAST: dummy_n = `SFRC_DTR_FAST_DUMMY;
      `SFRC_OP_DUAL_OUT: dummy_n = `SFRC_DUAL_OUT_DUMMY;
      `SFRC_OP_QUAD_OUT: dummy_n = `SFRC_QUAD_OUT_DUMMY;
      `SFRC_OP_DUAL_IO: dummy_n = cfg_q[`SFRC_CFG_DUMMY_SEL_BIT] ? `SFRC_DUAL_IO_EXTRA : 4'h0;
      `SFRC_OP_DTR_DUAL_IO: dummy_n = `SFRC_DTR_DUAL_IO_DUMMY;
      default: dummy_n = 4'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting
  wire [2:0] iw = (phase_q == PH_ADDR || phase_q == PH_MODE) ? aw : (four ? 3'h4 : 3'h1);
  localparam [2:0] PH_WDATA_OK = PH_IGN;
  wire in_ph = (phase_q == PH_CMD) || (phase_q == PH_ADDR) ||
               (phase_q == PH_MODE) || (phase_q == PH_WDATA_OK);
  reg wdata_q;
  wire samp = (rise || (fall && is_dtr && (phase_q == PH_ADDR || phase_q == PH_MODE))) && in_ph;
  reg [23:0] sh_next;
  always @* begin
    case (iw)
      3'h2: sh_next = {in_sr_q[21:0], io[1:0]};
      3'h4: sh_next = {in_sr_q[19:0], io};
      default: sh_next = {in_sr_q[22:0], io[0]};
    endcase
  end
  wire [5:0] cnt_next = bit_cnt_q + {3'h0, iw};
  wire addr_done = samp && (phase_q == PH_ADDR) && (cnt_next >= `SFRC_ADDR_BITS);
  wire flush = cs_rise | addr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Output shifting
  wire [7:0] fifo_data;
  wire fifo_valid, fifo_in_ready;
  wire [7:0] stat_byte = (cmd_q == `SFRC_OP_CFG_RD) ? cfg_q : {6'h00, wel_q, busy_q};
  wire drv = (fall || (rise && is_dtr && phase_q == PH_DATA)) &&
             (phase_q == PH_DATA || phase_q == PH_STAT);
  wire [7:0] cur_byte = (ocnt_q == 4'h0) ?
                        ((phase_q == PH_STAT) ? stat_byte : fifo_data) : osr_q;
  wire pop = drv && (phase_q == PH_DATA) && (ocnt_q == 4'h0) && fifo_valid;
  wire [7:0] learn_pat = `SFRC_LEARN_PAT;
  wire [2:0] pat_idx = dum_q[2:0] - 3'h1;
  wire learn_on = cfg_q[`SFRC_CFG_LEARN_BIT] && (is_dtr || cmd_q == `SFRC_OP_FAST) &&
                  (dum_q <= 4'h8) && (dum_q != 4'h0);

  always @(posedge CLK) begin
    if (RST) begin
      osr_q <= 8'h00;
      ocnt_q <= 4'h0;
      io_o_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (cs_rise || cs_fall) begin
      ocnt_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (drv) begin
      case (ow)
        3'h2: io_o_q <= {2'h0, cur_byte[7:6]};
        3'h4: io_o_q <= cur_byte[7:4];
        default: io_o_q <= {2'h0, cur_byte[7], 1'b0};
      endcase
      io_oe_q <= lane_mask(ow);
      osr_q <= cur_byte << ow;
      ocnt_q <= ((ocnt_q == 4'h0) ? 4'h8 : ocnt_q) - {1'b0, ow};
    end else if (fall && phase_q == PH_DUMMY) begin
      if (learn_on) begin
        io_o_q <= {4{learn_pat[pat_idx]}} & lane_mask(dw);
        io_oe_q <= lane_mask(dw);
      end else
        io_oe_q <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge CLK) begin
    if (RST) begin
      phase_q <= PH_IDLE;
      wdata_q <= 1'b0;
      cmd_q <= 8'h00;
      cont_cmd_q <= 8'h00;
      bit_cnt_q <= 6'h00;
      in_sr_q <= 24'h000000;
      dum_q <= 4'h0;
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      busy_q <= 1'b0;
      cont_q <= 1'b0;
      tw_cnt_q <= 20'h00000;
      cfg_q <= `SFRC_CFG_RST;
      param_q <= `SFRC_PARAM_RST;
    end else begin
      busy_q <= busy_any;
      if (wip_q) begin
        if (tw_cnt_q >= TW_LAST) begin
          wip_q <= 1'b0;
          wel_q <= 1'b0;
        end else
          tw_cnt_q <= tw_cnt_q + 20'h00001;
      end
      if (cs_rise) begin
        phase_q <= PH_IDLE;
        wdata_q <= 1'b0;
        if (wdata_q && bit_cnt_q == `SFRC_DATA_BITS) begin
          if (cmd_q == `SFRC_OP_CFG_WR && wel_q && !busy_any) begin
            cfg_q <= in_sr_q[7:0];
            wip_q <= 1'b1;
            tw_cnt_q <= 20'h00000;
          end else if (cmd_q == `SFRC_OP_SET_PARAM)
            param_q <= in_sr_q[7:0];
        end
      end else if (cs_fall) begin
        bit_cnt_q <= 6'h00;
        in_sr_q <= 24'h000000;
        wdata_q <= 1'b0;
        if (cont_q) begin
          cmd_q <= cont_cmd_q;
          phase_q <= busy_any ? PH_IGN : PH_ADDR;
        end else
          phase_q <= PH_CMD;
      end else if (samp) begin
        in_sr_q <= sh_next;
        bit_cnt_q <= cnt_next;
        if (phase_q == PH_CMD && cnt_next >= `SFRC_OP_BITS) begin
          cmd_q <= sh_next[7:0];
          bit_cnt_q <= 6'h00;
          phase_q <= PH_IGN;
          if (sh_next[7:0] == `SFRC_OP_STAT_RD || sh_next[7:0] == `SFRC_OP_CFG_RD)
            phase_q <= PH_STAT;
          else if (!busy_any) begin
            if (sh_next[7:0] == `SFRC_OP_UNLOCK)
              wel_q <= 1'b1;
            else if (sh_next[7:0] == `SFRC_OP_CONT_RST)
              cont_q <= 1'b0;
            else if (sh_next[7:0] == `SFRC_OP_CFG_WR || sh_next[7:0] == `SFRC_OP_SET_PARAM)
              wdata_q <= 1'b1;
            else if (is_read(sh_next[7:0]))
              phase_q <= PH_ADDR;
          end
        end else if (addr_done) begin
          bit_cnt_q <= 6'h00;
          if (has_mode)
            phase_q <= PH_MODE;
          else if (dummy_n == 4'h0)
            phase_q <= PH_DATA;
          else begin
            phase_q <= PH_DUMMY;
            dum_q <= dummy_n;
          end
        end else if (phase_q == PH_MODE && cnt_next >= `SFRC_MODE_BITS) begin
          cont_q <= (sh_next[5:4] == `SFRC_CONT_MATCH);
          cont_cmd_q <= cmd_q;
          bit_cnt_q <= 6'h00;
          dum_q <= dummy_n;
          phase_q <= (dummy_n == 4'h0) ? PH_DATA : PH_DUMMY;
        end else if (wdata_q && cnt_next > `SFRC_DATA_BITS)
          bit_cnt_q <= `SFRC_DATA_BITS + 6'h01;
      end else if (rise && phase_q == PH_DUMMY) begin
        dum_q <= dum_q - 4'h1;
        if (dum_q == 4'h1)
          phase_q <= PH_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array prefetch into the read buffer
  wire push = MEM_VALID && pend_q && !drop_q && !flush;
  always @(posedge CLK) begin
    if (RST) begin
      fetch_addr_q <= 24'h000000;
      mem_addr_q <= 24'h000000;
      mem_rd_q <= 1'b0;
      pend_q <= 1'b0;
      drop_q <= 1'b0;
      fetch_on_q <= 1'b0;
    end else begin
      mem_rd_q <= 1'b0;
      if (MEM_VALID) begin
        pend_q <= 1'b0;
        drop_q <= 1'b0;
      end
      if (flush) begin
        fetch_on_q <= addr_done;
        fetch_addr_q <= sh_next;
        if (pend_q && !MEM_VALID)
          drop_q <= 1'b1;
      end else if (fetch_on_q && !pend_q && fifo_in_ready) begin
        mem_rd_q <= 1'b1;
        mem_addr_q <= fetch_addr_q;
        fetch_addr_q <= fetch_addr_q + 24'h000001;
        pend_q <= 1'b1;
      end
    end
  end

  sfrc_fifo #(
    .W(`SFRC_FIFO_W),
    .D(`SFRC_FIFO_D)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .flush(flush),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(MEM_RDATA),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign IO_O = io_o_q;
  assign IO_OE = io_oe_q;
  assign MEM_RD = mem_rd_q;
  assign MEM_ADDR = mem_addr_q;
  assign BUSY_FLAG = busy_q;
  assign WRITE_UNLOCK_LATCH = wel_q;
  assign CONFIG_REG = cfg_q;
  assign READ_PARAM = param_q;
  assign CONTINUOUS_MODE = cont_q;
endmodule // sfrc_top
`default_nettype wire

// ---- rtl/sfrc_defines.vh ----
// Constants of the serial flash read and configuration write logic.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SFRC_DEFINES_VH
`define SFRC_DEFINES_VH
// Opcodes
`define SFRC_OP_UNLOCK 8'h06
`define SFRC_OP_CFG_WR 8'h11
`define SFRC_OP_SET_PARAM 8'hc0
`define SFRC_OP_STAT_RD 8'h05
`define SFRC_OP_CFG_RD 8'h15
`define SFRC_OP_CONT_RST 8'hff
`define SFRC_OP_RD 8'h03
`define SFRC_OP_FAST 8'h0b
`define SFRC_OP_DTR_FAST 8'h0d
`define SFRC_OP_DUAL_OUT 8'h3b
`define SFRC_OP_DUAL_IO 8'hbb
`define SFRC_OP_DTR_DUAL_IO 8'hbd
`define SFRC_OP_QUAD_OUT 8'h6b
// Field positions, reset values, mode match value and learning pattern
`define SFRC_CFG_LEARN_BIT 0
`define SFRC_CFG_DUMMY_SEL_BIT 1
`define SFRC_PARAM_DUM_HI 5
`define SFRC_PARAM_DUM_LO 4
`define SFRC_CFG_RST 8'h00
`define SFRC_PARAM_RST 8'h00
`define SFRC_CONT_MATCH 2'h2
`define SFRC_LEARN_PAT 8'h34
// Frame lengths in bits
`define SFRC_OP_BITS 6'h08
`define SFRC_ADDR_BITS 6'h18
`define SFRC_MODE_BITS 6'h08
`define SFRC_DATA_BITS 6'h08
// Dummy clocks
`define SFRC_FAST_DUMMY 4'h8
`define SFRC_DTR_FAST_DUMMY 4'h6
`define SFRC_DUAL_OUT_DUMMY 4'h8
`define SFRC_QUAD_OUT_DUMMY 4'h8
`define SFRC_DUAL_IO_EXTRA 4'h4
`define SFRC_DTR_DUAL_IO_DUMMY 4'h4
`define SFRC_FOUR_WIRE_DUMMY_BASE 4'h4
// Timing
`define SFRC_CLK_NS 20
`define SFRC_TW_NS 1000000
`define SFRC_TW_CYC ((`SFRC_TW_NS + `SFRC_CLK_NS - 1) / `SFRC_CLK_NS)
// Read buffer
`define SFRC_FIFO_W 8
`define SFRC_FIFO_D 8
`endif

// ---- rtl/sfrc_fifo.v ----
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sfrc_fifo #(
  parameter W = 8,
  parameter D = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam AW = $clog2(D);
  localparam [AW:0] FULL = D;
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q, rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  always @(posedge clk) begin
    if (push)
      mem[wp_q] <= in_data;
  end
  always @(posedge clk) begin
    if (rst || flush) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_q <= (wp_q == D - 1) ? {AW{1'b0}} : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == D - 1) ? {AW{1'b0}} : rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // sfrc_fifo
`default_nettype wire

// ---- tb/sfrc_top_monitor.sv ----
// Checker of the flash command block: write cycle, config write, array reads.
// Assumes binding to sfrc_top with the same cycle-time parameter.
`timescale 1ns/1ps
`default_nettype none
module sfrc_monitor #(
  parameter int TW_CYCLES = 20
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Link and array port
  input wire CS_N,
  input wire [3:0] IO_OE,
  input wire MEM_RD,
  input wire [23:0] MEM_ADDR,
  // Status
  input wire EXT_BUSY,
  input wire BUSY_FLAG,
  input wire WRITE_UNLOCK_LATCH,
  input wire [7:0] CONFIG_REG
);
  logic own_q;
  logic busy_p_q;
  logic ext_p_q;
  logic seen_q;
  logic [23:0] last_q;
  int cnt_q;
  // Tracks own write cycles and the last array request of a frame
  always @(posedge CLK) begin
    if (RST) begin
      own_q <= 1'b0;
      busy_p_q <= 1'b0;
      ext_p_q <= 1'b0;
      seen_q <= 1'b0;
      last_q <= 24'h000000;
      cnt_q <= 0;
    end else begin
      busy_p_q <= BUSY_FLAG;
      ext_p_q <= EXT_BUSY;
      seen_q <= !CS_N && (seen_q || MEM_RD);
      if (MEM_RD)
        last_q <= MEM_ADDR;
      if (BUSY_FLAG && !busy_p_q) begin
        own_q <= !ext_p_q;
        cnt_q <= 1;
      end else if (BUSY_FLAG)
        cnt_q <= cnt_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_oe_idle;
    @(posedge CLK) disable iff (RST) CS_N[*6] |-> IO_OE == 4'h0;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("outputs driven while deselected");
  property p_busy_len;
    @(posedge CLK) disable iff (RST) own_q && busy_p_q && !BUSY_FLAG |-> cnt_q >= TW_CYCLES - 1 && cnt_q <= TW_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_wel_clr;
    @(posedge CLK) disable iff (RST) $fell(BUSY_FLAG) && own_q |-> ##[0:1] !WRITE_UNLOCK_LATCH;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("unlock latch kept after cycle");
  property p_cfg_start;
    @(posedge CLK) disable iff (RST) !$stable(CONFIG_REG) |-> ##[0:1] BUSY_FLAG;
  endproperty
  a_cfg_start: assert property (p_cfg_start) else $error("config changed without cycle");
  property p_cfg_latch;
    @(posedge CLK) disable iff (RST) $changed(CONFIG_REG) |-> $past(WRITE_UNLOCK_LATCH);
  endproperty
  a_cfg_latch: assert property (p_cfg_latch) else $error("config changed while locked");
  property p_rd_busy;
    @(posedge CLK) disable iff (RST) BUSY_FLAG[*8] |-> !MEM_RD;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("array read while busy");
  property p_addr_inc;
    @(posedge CLK) disable iff (RST) MEM_RD && seen_q && !CS_N |-> MEM_ADDR == last_q + 24'h000001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("read address not incremented");
  property p_ext_busy;
    @(posedge CLK) disable iff (RST) EXT_BUSY |=> BUSY_FLAG;
  endproperty
  a_ext_busy: assert property (p_ext_busy) else $error("busy flag missing");
endmodule // sfrc_monitor
bind sfrc_top sfrc_monitor #(.TW_CYCLES(TW_CYCLES)) u_monitor (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .IO_OE(IO_OE), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
  .EXT_BUSY(EXT_BUSY), .BUSY_FLAG(BUSY_FLAG), .WRITE_UNLOCK_LATCH(WRITE_UNLOCK_LATCH),
  .CONFIG_REG(CONFIG_REG)
);
`default_nettype wire

// ---- tb/sfrc_host_model.sv ----
// Host controller model driving the serial link of the flash block.
// Assumes the device answers well within half a serial clock of each fall.
`timescale 1ns/1ps
`default_nettype none
module sfrc_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output wire [3:0] io_i,
  // Device drive
  input wire [3:0] io_o,
  input wire [3:0] io_oe
);
  logic [3:0] hv = 4'h0;
  logic [3:0] hen = 4'h0;
  // Wire level: device where enabled, host where driving, else inverse of last
  assign io_i = (io_oe & io_o) | (~io_oe & hen & hv) | (~io_oe & ~hen & ~hv);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  task automatic start();
    cs_n = 1'b0;
    #200;
  endtask
  task automatic send(input logic [23:0] v, input int nb, input int w);
    for (int k = 0; k < nb / w; k++) begin
      hen = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
      for (int j = 0; j < w; j++)
        hv[j] = v[nb - 1 - k * w - (w - 1 - j)];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
  task automatic recv(output logic [7:0] b, input int w);
    hen = 4'h0;
    b = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      #80 sclk = 1'b1;
      #70;
      for (int j = w - 1; j >= 0; j--)
        b = {b[6:0], (w == 1) ? io_i[1] : io_i[j]};
      #10 sclk = 1'b0;
    end
  endtask
  task automatic dummy(input int n);
    hen = 4'h0;
    repeat (n) begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
  task automatic exit_cont();
    start();
    hen = 4'h1;
    hv = 4'hf;
    repeat (16) begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    stop();
  endtask
  task automatic stop();
    #80 cs_n = 1'b1;
    hen = 4'h0;
    #400;
  endtask
endmodule // sfrc_host_model
`default_nettype wire

// ---- tb/sfrc_testbench.sv ----
// Self-checking bench of the flash command block with host and array models.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
  typedef struct packed {logic [7:0] op; int aw; int md; int dum; int dw; logic [23:0] addr; int n;} sfrc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext_busy = 1'b0;
  logic mem_valid = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic four = 1'b0;
  logic [7:0] pat;
  wire sclk, cs_n, mem_rd, busy, latch, cont;
  wire [3:0] io_i, io_o, io_oe;
  wire [23:0] mem_addr;
  wire [7:0] cfg, param;
  int error_cnt = 0;
  int checked = 0;
  int rd_cnt = 0;
  int wait_cnt = 0;
  int n;
  sfrc_row_t rows [5] = '{'{8'h03, 1, 0, 0, 1, 24'hfffffe, 3}, '{8'h0b, 1, 0, 8, 1, 24'h000010, 2},
    '{8'h3b, 1, 0, 8, 2, 24'h123456, 3}, '{8'h6b, 1, 0, 8, 4, 24'h00abcd, 3},
    '{8'hbb, 2, 1, 0, 2, 24'h7ffffe, 3}};
  always #10 clk = ~clk;
  sfrc_top #(.TW_CYCLES(400)) dut (.CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .IO_I(io_i), .IO_O(io_o),
    .IO_OE(io_oe), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .MEM_VALID(mem_valid),
    .EXT_BUSY(ext_busy), .FOUR_WIRE_COMMAND_MODE(four), .BUSY_FLAG(busy), .WRITE_UNLOCK_LATCH(latch),
    .CONFIG_REG(cfg), .READ_PARAM(param), .CONTINUOUS_MODE(cont));
  sfrc_host_model host (.sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'ha5;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Array model: answers after one or three cycles, by address parity
  always @(posedge clk) begin
    #2;
    mem_valid = 1'b0;
    if (wait_cnt != 0) begin
      wait_cnt = wait_cnt - 1;
      if (wait_cnt == 0) begin
        mem_valid = 1'b1;
        mem_rdata = mem_byte(req_addr);
      end
    end
    if (mem_rd === 1'b1) begin
      req_addr = mem_addr;
      wait_cnt = mem_addr[0] ? 3 : 1;
      rd_cnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic do_read(input logic [7:0] op, input bit use_op, input int aw, input int md,
    input logic [7:0] mode, input int dum, input int dw, input logic [23:0] addr, input int cnt);
    logic [7:0] b;
    logic [23:0] a;
    host.start();
    if (use_op)
      host.send({16'h0000, op}, 8, four ? 4 : 1);
    host.send(addr, 24, aw);
    if (md != 0)
      host.send({16'h0000, mode}, 8, aw);
    host.dummy(dum);
    for (int i = 0; i < cnt; i++) begin
      a = addr + 24'(i);
      host.recv(b, dw);
      `CHK("read byte", mem_byte(a), b)
    end
    host.stop();
  endtask
  task automatic frame(input logic [23:0] v, input int nb);
    host.start();
    host.send(v, nb, 1);
    host.stop();
  endtask
  task automatic refused(input logic [7:0] op);
    n = rd_cnt;
    host.start();
    host.send({16'h0000, op}, 8, 1);
    host.send(24'h000040, 24, 1);
    host.dummy(8);
    host.stop();
  endtask
  task automatic status(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] b;
    host.start();
    host.send({16'h0000, op}, 8, 1);
    host.recv(b, 1);
    host.stop();
    `CHK("status byte", exp, b)
  endtask
  task automatic wait_idle();
    for (n = 0; n < 1000 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #2;
    end
    `CHK("cycle ended", 1'b0, busy)
  endtask
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #2 rst = 1'b0;
    foreach (rows[i])
      do_read(rows[i].op, 1, rows[i].aw, rows[i].md, 8'h00, rows[i].dum, rows[i].dw, rows[i].addr, rows[i].n);
    // Config write: refused while locked, refused off the byte boundary, then taken
    frame({8'h00, 8'h11, 8'h02}, 16);
    `CHK("cfg locked", 8'h00, cfg)
    frame(24'h000006, 8);
    `CHK("unlock latch", 1'b1, latch)
    frame({7'h00, 8'h11, 8'h02, 1'b1}, 17);
    `CHK("cfg off boundary", 8'h00, cfg)
    frame({8'h00, 8'h11, 8'h02}, 16);
    `CHK("busy", 1'b1, busy)
    `CHK("cfg", 8'h02, cfg)
    status(8'h05, 8'h03);
    refused(8'h0b);
    `CHK("read while busy", n, rd_cnt)
    `CHK("cfg kept", 8'h02, cfg)
    wait_idle();
    `CHK("latch after cycle", 1'b0, latch)
    status(8'h05, 8'h00);
    status(8'h15, 8'h02);
    // Dummy select now set: dual I/O read carries four extra dummy clocks
    do_read(8'hbb, 1, 2, 1, 8'h20, 4, 2, 24'h000100, 2);
    `CHK("cont armed", 1'b1, cont)
    do_read(8'hbb, 0, 2, 1, 8'h00, 4, 2, 24'h000200, 2);
    `CHK("cont cleared", 1'b0, cont)
    do_read(8'hbb, 1, 2, 1, 8'h20, 4, 2, 24'h000300, 1);
    host.exit_cont();
    `CHK("cont left", 1'b0, cont)
    frame({8'h00, 8'hc0, 8'h30}, 16);
    `CHK("read param", 8'h30, param)
    @(posedge clk);
    #2 four = 1'b1;
    do_read(8'h0b, 1, 4, 0, 8'h00, 10, 4, 24'h000400, 2);
    @(posedge clk);
    #2 four = 1'b0;
    frame(24'h000006, 8);
    frame({8'h00, 8'h11, 8'h03}, 16);
    wait_idle();
    host.start();
    host.send({16'h0000, 8'h0b}, 8, 1);
    host.send(24'h000040, 24, 1);
    host.recv(pat, 1);
    host.stop();
    `CHK("learn pattern", 8'h34, pat)
    @(posedge clk);
    #2 ext_busy = 1'b1;
    repeat (3) @(posedge clk);
    `CHK("ext busy", 1'b1, busy)
    refused(8'h3b);
    `CHK("read while ext busy", n, rd_cnt)
    @(posedge clk);
    #2 ext_busy = 1'b0;
    @(posedge clk);
    #2 rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    `CHK("reset state", 52'h0, {cfg, param, latch, busy, cont, mem_rd, io_oe, mem_addr, io_o})
    do_read(8'h03, 1, 1, 0, 8'h00, 0, 1, 24'h000020, 2);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
